// file: design/dao_ctrl.sv
// dual converter output control: sampling, latency pipe, format, buses, apb
`timescale 1ns/10ps
`default_nettype none

module dao_ctrl
   import dao_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   // analog front end levels, signed, zero at mid scale
   input wire logic signed [RAW_W-1:0] analog_a_level,
   input wire logic signed [RAW_W-1:0] analog_b_level,
   // control pins
   input wire logic [1:0] format_stabilizer_select,
   input wire logic bus_a_output_enable_n,
   input wire logic bus_b_output_enable_n,
   input wire logic power_down_input,
   input wire logic interleave_select,
   // output buses, each with its drive enable
   output logic [DAO_W-1:0] bus_a_word_q,
   output logic bus_a_oe_q,
   output logic [DAO_W-1:0] bus_b_word_q,
   output logic bus_b_oe_q,
   // status pins
   output logic stabilizer_on_q,
   output logic powered_down_q,
   output logic capture_ready_q
);

   // synchronised pins
   dao_pins_t pins_raw;
   dao_pins_t pins_s1_q;
   dao_pins_t pins_q;
   // conversion timing and pipe
   logic phase_q;
   dao_pair_t pipe_q [LATENCY];
   dao_pair_t raw_q;
   logic [DAO_W-1:0] code_a_w;
   logic [DAO_W-1:0] code_b_w;
   // control and status
   logic [1:0] ctrl_q;
   logic ovf_q;
   // fifo side
   logic fifo_in_ready;
   logic fifo_out_valid;
   dao_pair_t fifo_out_data;
   logic [FIFO_CNT_W-1:0] fifo_level;

   // saturate the analog level into an offset binary code
   function automatic logic [DAO_W-1:0] sat_code(
      input logic signed [RAW_W-1:0] lvl);
      logic signed [SUM_W-1:0] sum;
      sum = SUM_W'(lvl) + CODE_MID;
      if (sum < SUM_MIN)
         sat_code = CODE_ZERO;
      else if (sum > SUM_MAX)
         sat_code = CODE_MAX;
      else
         sat_code = sum[DAO_W-1:0];
   endfunction : sat_code

   // every pin comes from outside the clock domain
   assign pins_raw.level_a = analog_a_level;
   assign pins_raw.level_b = analog_b_level;
   assign pins_raw.fss = dao_level_t'(format_stabilizer_select);
   assign pins_raw.oea_n = bus_a_output_enable_n;
   assign pins_raw.oeb_n = bus_b_output_enable_n;
   assign pins_raw.pd = power_down_input;
   assign pins_raw.mux = interleave_select;

   // two-flop synchroniser; the analog word is a sampled level, so a
   // torn word costs one sample only and is accepted here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pins_s1_q <= '{fss: LVL_FLOAT, oea_n: 1'b1, oeb_n: 1'b1, default: '0};
         pins_q <= '{fss: LVL_FLOAT, oea_n: 1'b1, oeb_n: 1'b1, default: '0};
      end
      else
      begin
         pins_s1_q <= pins_raw;
         pins_q <= pins_s1_q;
      end
   end

   // mode decode from the four-state pin, the interleave pin, the power-down pin and the ctrl power-down bit
   wire logic sample_edge = ~phase_q;
   wire logic fmt_twos = (pins_q.fss == LVL_AGND) | (pins_q.fss == LVL_MID);
   wire logic dcs_on = (pins_q.fss == LVL_AGND) | (pins_q.fss == LVL_SUPPLY);
   wire logic pd_eff = pins_q.pd | ctrl_q[CTRL_PD_BIT];
   wire logic mux_mode = pins_q.mux;
   wire logic [DAO_W-1:0] fmt_mask = fmt_twos ? CODE_MSB : CODE_ZERO;
   assign code_a_w = sat_code(pins_q.level_a);
   assign code_b_w = sat_code(pins_q.level_b);

   // next bus words: bit 0 is the lsb, bit 11 the msb
   wire dao_pair_t head = pipe_q[LATENCY-1];
   wire logic [DAO_W-1:0] fa_head = head.a ^ fmt_mask;
   wire logic [DAO_W-1:0] fb_head = head.b ^ fmt_mask;
   wire logic [DAO_W-1:0] fb_raw = raw_q.b ^ fmt_mask;
   wire logic [DAO_W-1:0] ind_a = {{(DAO_W-1){1'b0}}, 1'b1};

   // conversion clock is pclk/2; phase 0 cycles end in the sampling edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_q <= 1'b0;
      else
         phase_q <= ~phase_q;
   end

   // latency pipe: a pair enters at the sampling edge and leaves seven
   // periods later; it keeps running in power-down so timing never slips
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < LATENCY; i++)
            pipe_q[i] <= '0;
         raw_q <= '0;
      end
      else if (sample_edge)
      begin
         pipe_q[0] <= '{b: code_b_w, a: code_a_w};
         for (int i = 1; i < LATENCY; i++)
            pipe_q[i] <= pipe_q[i-1];
         raw_q <= head;
      end
   end

   // output buses: parallel updates once a period, multiplex sends a in
   // the first half and b in the second, the indicator tracking them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_a_word_q <= CODE_ZERO;
         bus_b_word_q <= CODE_ZERO;
      end
      else if (pd_eff)
      begin
         bus_a_word_q <= CODE_ZERO;
         bus_b_word_q <= CODE_ZERO;
      end
      else if (sample_edge)
      begin
         bus_a_word_q <= fa_head;
         bus_b_word_q <= mux_mode ? ind_a : fb_head;
      end
      else if (mux_mode)
      begin
         bus_a_word_q <= fb_raw;
         bus_b_word_q <= CODE_ZERO;
      end
   end

   // drive enables and mode pins; enable follows its pin as a level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_a_oe_q <= 1'b0;
         bus_b_oe_q <= 1'b0;
         stabilizer_on_q <= 1'b0;
         powered_down_q <= 1'b0;
         capture_ready_q <= 1'b0;
      end
      else
      begin
         bus_a_oe_q <= ~pins_q.oea_n;
         bus_b_oe_q <= ~pins_q.oeb_n;
         stabilizer_on_q <= dcs_on;
         powered_down_q <= pd_eff;
         capture_ready_q <= fifo_in_ready;
      end
   end

   // capture buffer: one pair per period while enabled and powered up;
   // the pipe cannot stall, so a full buffer drops and flags overflow
   wire logic cap_valid = sample_edge & ctrl_q[CTRL_FIFO_BIT] & ~pd_eff;
   wire logic cap_drop = cap_valid & ~fifo_in_ready;

   // apb decode; every access takes one wait state so read data is a flop
   wire logic acc_first = psel & penable & ~pready_q;
   wire logic acc_done = psel & penable & pready_q;
   wire logic hit_ctrl = (paddr == ADDR_CTRL);
   wire logic hit_status = (paddr == ADDR_STATUS);
   wire logic hit_data = (paddr == ADDR_DATA);
   wire logic hit_clear = (paddr == ADDR_CLEAR);
   wire logic mapped = hit_ctrl | hit_status | hit_data | hit_clear;
   wire logic wr_ctrl = acc_done & pwrite & hit_ctrl;
   wire logic wr_clear = acc_done & pwrite & hit_clear;
   wire logic pop = acc_done & ~pwrite & hit_data & fifo_out_valid;

   // read mux
   logic [31:0] status_w;
   logic [31:0] rdata_w;
   always_comb
   begin
      status_w = DATA_ZERO;
      status_w[ST_PD_BIT] = pd_eff;
      status_w[ST_MUX_BIT] = mux_mode;
      status_w[ST_DCS_BIT] = dcs_on;
      status_w[ST_TWOS_BIT] = fmt_twos;
      status_w[ST_LVL_LSB +: 2] = pins_q.fss;
      status_w[ST_OVF_BIT] = ovf_q;
      status_w[ST_RDY_BIT] = fifo_in_ready;
      status_w[ST_CNT_LSB +: FIFO_CNT_W] = fifo_level;
      rdata_w = DATA_ZERO;
      if (hit_ctrl)
         rdata_w[1:0] = ctrl_q;
      else if (hit_status)
         rdata_w = status_w;
      else if (hit_data && fifo_out_valid)
      begin
         rdata_w[DAO_W-1:0] = fifo_out_data.a;
         rdata_w[DATA_B_LSB +: DAO_W] = fifo_out_data.b;
      end
   end

   // apb answer flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= DATA_ZERO;
      end
      else
      begin
         pready_q <= acc_first;
         pslverr_q <= acc_first & ~mapped;
         prdata_q <= acc_first ? rdata_w : DATA_ZERO;
      end
   end

   // control register and sticky overflow; a drop beats a clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= CTRL_RESET;
         ovf_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= pwdata[1:0];
         ovf_q <= cap_drop | (ovf_q & ~wr_clear);
      end
   end

   dao_fifo #(
      .WIDTH($bits(dao_pair_t)),
      .DEPTH(FIFO_DEPTH),
      .CNT_W(FIFO_CNT_W)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(cap_valid),
      .in_ready(fifo_in_ready),
      .in_data(head),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_mux_a_word;
      bus_b_word_q[0] && bus_a_word_q == ($past(fa_head));
   endsequence
   sequence s_mux_b_word;
      !bus_b_word_q[0] && bus_a_word_q == ($past(fb_raw));
   endsequence

   // the first edge after release still sees reset values, so skip it
   AST_PHASE: assert property ($past(presetn) |->
      phase_q != $past(phase_q))
      else $error("sampling phase stopped toggling");
   AST_LATENCY: assert property ($past(presetn) && sample_edge |->
      ##15 raw_q.a == $past(code_a_w, 15) && raw_q.b == $past(code_b_w, 15))
      else $error("result did not emerge after seven periods");
   AST_SAT_LOW: assert property (pins_q.level_a < -RAW_W'(CODE_MID) |-> code_a_w == CODE_ZERO)
      else $error("under range did not give code zero");
   AST_SAT_HIGH: assert property (SUM_W'(pins_q.level_a) + CODE_MID > SUM_MAX |-> code_a_w == CODE_MAX)
      else $error("over range did not give full code");
   AST_FMT_MID: assert property (pins_q.fss == LVL_MID |=> !stabilizer_on_q)
      else $error("mid level left the stabilizer on");
   AST_FMT_SUPPLY: assert property (pins_q.fss == LVL_SUPPLY |=> stabilizer_on_q)
      else $error("supply level left the stabilizer off");
   AST_TWOS: assert property (sample_edge && !pd_eff && !mux_mode |=> bus_a_word_q == ($past(fmt_twos) ? raw_q.a ^ CODE_MSB : raw_q.a))
      else $error("bus a word not in the selected format");
   // the synchroniser restarts at release, so the count starts after it
   AST_OE: assert property ($past(presetn) ##0
      (!bus_a_output_enable_n)[*4] |-> bus_a_oe_q)
      else $error("bus a not driven with its enable low");
   AST_PAR: assert property (sample_edge && !pd_eff && !mux_mode |=> bus_b_word_q == $past(fb_head))
      else $error("parallel bus b word wrong");
   // a word with indicator high, then the b word with indicator low
   AST_MUX: assert property (
      sample_edge && !pd_eff && mux_mode ##1 !pd_eff && mux_mode
      |-> s_mux_a_word ##1 s_mux_b_word)
      else $error("multiplex words or indicator out of step");
   AST_PD: assert property (pd_eff |=> bus_a_word_q == CODE_ZERO && bus_b_word_q == CODE_ZERO)
      else $error("power-down did not quiet the buses");
   AST_APB: assert property (acc_first |=> pready_q ##1 !pready_q)
      else $error("apb answer not exactly one wait state");

endmodule : dao_ctrl

`default_nettype wire

// file: design/dao_pkg.sv
// shared constants, types and register map of the dual converter output block
package dao_pkg;

   // result word and raw analog level widths
   localparam int DAO_W = 12;
   localparam int RAW_W = 14;
   localparam int SUM_W = RAW_W + 1;
   // pipeline depth in conversion periods, pclk cycles per period
   localparam int LATENCY = 7;
   localparam int PERIOD_CYC = 2;
   localparam int LATENCY_CYC = LATENCY * PERIOD_CYC;

   // code limits and format constants
   localparam logic [DAO_W-1:0] CODE_ZERO = 12'h000;
   localparam logic [DAO_W-1:0] CODE_MAX = 12'hFFF;
   localparam logic [DAO_W-1:0] CODE_MSB = 12'h800;
   localparam logic signed [SUM_W-1:0] CODE_MID = 15'sh0800;
   localparam logic signed [SUM_W-1:0] SUM_MAX = 15'sh0FFF;
   localparam logic signed [SUM_W-1:0] SUM_MIN = 15'sh0000;

   // apb register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CLEAR = 8'h0C;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // ctrl fields
   localparam int CTRL_PD_BIT = 0;
   localparam int CTRL_FIFO_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // status fields
   localparam int ST_PD_BIT = 0;
   localparam int ST_MUX_BIT = 1;
   localparam int ST_DCS_BIT = 2;
   localparam int ST_TWOS_BIT = 3;
   localparam int ST_LVL_LSB = 4;
   localparam int ST_OVF_BIT = 6;
   localparam int ST_RDY_BIT = 7;
   localparam int ST_CNT_LSB = 8;
   // data register: channel b word above channel a word
   localparam int DATA_B_LSB = 16;

   // capture buffer
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_CNT_W = 6;

   // levels of the four-state select pin, as decoded by the pad comparators
   typedef enum logic [1:0] {
      LVL_AGND,
      LVL_MID,
      LVL_FLOAT,
      LVL_SUPPLY
   } dao_level_t;

   // one sample pair of both channels
   typedef struct packed {
      logic [DAO_W-1:0] b;
      logic [DAO_W-1:0] a;
   } dao_pair_t;

   // everything that arrives from outside the pclk domain
   typedef struct packed {
      logic signed [RAW_W-1:0] level_a;
      logic signed [RAW_W-1:0] level_b;
      dao_level_t fss;
      logic oea_n;
      logic oeb_n;
      logic pd;
      logic mux;
   } dao_pins_t;

endpackage : dao_pkg

// file: design/dao_fifo.sv
// capture buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module dao_fifo
   import dao_pkg::*;
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32,
   parameter int CNT_W = 6
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [CNT_W-1:0] level
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic push;
   logic pop;

   // handshakes; full and empty come straight from the count
   assign in_ready = (count_q != CNT_FULL);
   assign out_valid = (count_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr_q];
   assign level = count_q;

   // storage has no reset, only pointers and count do
   always_ff @(posedge pclk)
   begin
      if (push)
      begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   // pointers wrap naturally at a power-of-two depth
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_q + PTR_W'(push);
         rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
         count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_FIFO_NO_OVER: assert property (count_q <= CNT_FULL)
      else $error("capture buffer count past depth");
   AST_FIFO_COUNT: assert property (push && !pop |=> count_q == $past(count_q) + 1'b1)
      else $error("capture buffer count did not follow a push");

endmodule : dao_fifo

`default_nettype wire

// file: test/dao_capture_model.sv
// far-side capture logic: resolves both buses and splits muxed words
`timescale 1ns/10ps
`default_nettype none

module dao_capture_model
   import dao_pkg::*;
(
   // clock
   input wire logic pclk,
   // buses with their drive enables
   input wire logic [DAO_W-1:0] bus_a,
   input wire logic oe_a,
   input wire logic [DAO_W-1:0] bus_b,
   input wire logic oe_b,
   // output mode pin, shared with the converter
   input wire logic mux,
   // captured words
   output logic [DAO_W-1:0] cap_a,
   output logic [DAO_W-1:0] cap_b
);
   logic [DAO_W-1:0] wire_a, wire_b, last_a, last_b;

   // a released bus drifts: show the inverse of what was last driven
   assign wire_a = oe_a ? bus_a : ~last_a;
   assign wire_b = oe_b ? bus_b : ~last_b;

   // capture on the rising edge; in mux mode the indicator picks the slot
   always_ff @(posedge pclk)
   begin
      if (oe_a)
         last_a <= bus_a;
      if (oe_b)
         last_b <= bus_b;
      if (!mux)
      begin
         cap_a <= wire_a;
         cap_b <= wire_b;
      end
      else if (wire_b[0])
         cap_a <= wire_a;
      else
         cap_b <= wire_a;
   end
endmodule : dao_capture_model
`default_nettype wire

// file: test/dual_adc_output_control_tb_top.sv
// self-checking bench for the dual converter output control block
`timescale 1ns/10ps
`default_nettype none

module dual_adc_output_control_tb_top
   import dao_pkg::*;
;
   // clock, reset, apb
   logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata_q, rd;
   logic er;
   // pins and outputs
   logic signed [RAW_W-1:0] lvl_a, lvl_b;
   logic [1:0] fss;
   logic oea_n, oeb_n, pd_in, mux, oe_a, oe_b, stab, pdn, crdy;
   logic [DAO_W-1:0] bus_a, bus_b, cap_a, cap_b;
   int n_errors, compares;

   dao_ctrl u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .analog_a_level(lvl_a), .analog_b_level(lvl_b),
      .format_stabilizer_select(fss), .bus_a_output_enable_n(oea_n),
      .bus_b_output_enable_n(oeb_n), .power_down_input(pd_in),
      .interleave_select(mux), .bus_a_word_q(bus_a), .bus_a_oe_q(oe_a),
      .bus_b_word_q(bus_b), .bus_b_oe_q(oe_b), .stabilizer_on_q(stab),
      .powered_down_q(pdn), .capture_ready_q(crdy));

   dao_capture_model u_cap (
      .pclk(pclk), .bus_a(bus_a), .oe_a(oe_a), .bus_b(bus_b),
      .oe_b(oe_b), .mux(mux), .cap_a(cap_a), .cap_b(cap_b));

   // free-running clock
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      begin
         compares++;
         if (got !== exp)
         begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask : check

   task automatic stop_test;
      begin
         $display("compares %0d n_errors %0d", compares, n_errors);
         if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask : stop_test

   // expected output word: mid-scale offset, clamp, optional msb flip
   function automatic logic [DAO_W-1:0] code(
      input logic signed [RAW_W-1:0] l, input logic tw);
      int s;
      begin
         s = int'(l) + 32'sh0000_0800;
         if (s < 0)
            s = 0;
         if (s > 32'sh0000_0FFF)
            s = 32'sh0000_0FFF;
         code = DAO_W'(s) ^ (tw ? 12'h800 : 12'h000);
      end
   endfunction : code

   // one apb transfer; waits up to 20 cycles for pready, then counts an error
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [31:0] wd);
      int n;
      begin
         n = 0;
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         do
         begin
            @(posedge pclk);
            n++;
         end
         while (pready_q !== 1'b1 && n < 20);
         rd = prdata_q;
         er = pslverr_q;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n >= 20)
            check("apb answer", 1, 0);
      end
   endtask : apb

   // set pins, then let sync and pipeline settle
   task automatic pins(input logic signed [RAW_W-1:0] a, b,
                       input logic [1:0] f, input logic m);
      begin
         @(posedge pclk);
         lvl_a <= a;
         lvl_b <= b;
         fss <= f;
         mux <= m;
         repeat (30) @(negedge pclk);
      end
   endtask : pins

   task automatic t_formats;
      logic tw;
      begin
         for (int f = 0; f < 4; f++)
         begin
            tw = (f < 2);
            pins(100, -300, 2'(f), 1'b0);
            check("bus_a", code(100, tw), bus_a);
            check("bus_b", code(-300, tw), bus_b);
            check("stab", f == 0 || f == 3, stab);
            check("cap_a", code(100, tw), cap_a);
         end
      end
   endtask : t_formats

   task automatic t_sat;
      begin
         pins(8000, -8000, 2'h2, 1'b0);
         check("sat hi", 12'hFFF, bus_a);
         check("sat lo", 12'h000, bus_b);
         pins(2047, -2048, 2'h2, 1'b0);
         check("edge hi", 12'hFFF, bus_a);
         check("edge lo", 12'h000, bus_b);
         pins(-2049, 2048, 2'h2, 1'b0);
         check("under a", 12'h000, bus_a);
         check("over b", 12'hFFF, bus_b);
      end
   endtask : t_sat

   // a new level must not show before the pipeline delay has run
   task automatic t_latency;
      int n;
      begin
         pins(0, 0, 2'h2, 1'b0);
         n = 0;
         @(posedge pclk);
         lvl_a <= 1000;
         do
         begin
            @(negedge pclk);
            n++;
         end
         while (bus_a !== code(1000, 1'b0) && n < 40);
         check("latency", 1, n >= 16 && n <= 19);
      end
   endtask : t_latency

   task automatic t_mux;
      logic prev;
      begin
         pins(300, -700, 2'h2, 1'b1);
         prev = bus_b[0];
         for (int i = 0; i < 4; i++)
         begin
            @(negedge pclk);
            check("ind toggles", !prev, bus_b[0]);
            check("b upper", 0, bus_b[11:1]);
            check("muxed", code(bus_b[0] ? 300 : -700, 1'b0), bus_a);
            prev = bus_b[0];
         end
         check("cap_a", code(300, 1'b0), cap_a);
         check("cap_b", code(-700, 1'b0), cap_b);
         pins(100, -300, 2'h2, 1'b0);
      end
   endtask : t_mux

   task automatic t_oe;
      begin
         for (int i = 0; i < 3; i++)
         begin
            @(posedge pclk);
            oea_n <= (i == 0);
            oeb_n <= (i == 1);
            repeat (6) @(negedge pclk);
            check("oe_a", i != 0, oe_a);
            check("oe_b", i != 1, oe_b);
         end
      end
   endtask : t_oe

   task automatic t_pd;
      begin
         @(posedge pclk);
         pd_in <= 1'b1;
         repeat (6) @(negedge pclk);
         check("pd", 1, pdn);
         check("pd bus_a", 0, bus_a);
         check("pd bus_b", 0, bus_b);
         @(posedge pclk);
         pd_in <= 1'b0;
         apb(1'b1, ADDR_CTRL, 32'h0000_0001);
         repeat (4) @(negedge pclk);
         check("soft pd", 1, pdn);
         apb(1'b1, ADDR_CTRL, 32'h0000_0000);
         repeat (30) @(negedge pclk);
         check("awake", code(100, 1'b0), bus_a);
      end
   endtask : t_pd

   // registers, then fill the buffer until it refuses and drain it
   task automatic t_regs;
      begin
         apb(1'b0, ADDR_STATUS, 32'h0000_0000);
         check("status", 32'h0000_00A0, rd);
         apb(1'b0, 8'h10, 32'h0000_0000);
         check("unmapped", 1, er);
         check("unmapped data", 32'h0000_0000, rd);
         apb(1'b1, ADDR_CTRL, 32'h0000_0002);
         repeat (80) @(negedge pclk);
         check("full", 0, crdy);
         apb(1'b0, ADDR_STATUS, 32'h0000_0000);
         check("ovf lvl", 32'h0000_2040, rd & 32'h0000_3F40);
         apb(1'b1, ADDR_CTRL, 32'h0000_0000);
         for (int i = 0; i < 33; i++)
         begin
            apb(1'b0, ADDR_DATA, 32'h0000_0000);
            check("pair", i < 32 ? {4'h0, code(-300, 1'b0), 4'h0,
                  code(100, 1'b0)} : 32'h0000_0000, rd);
         end
         repeat (2) @(negedge pclk);
         check("ready", 1, crdy);
         apb(1'b1, ADDR_CLEAR, 32'h0000_0001);
         apb(1'b0, ADDR_STATUS, 32'h0000_0000);
         check("ovf clr", 0, rd[6]);
      end
   endtask : t_regs

   // cut a hang short
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      stop_test();
   end

   // main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      lvl_a = '0;
      lvl_b = '0;
      fss = 2'h2;
      oea_n = 1'b0;
      oeb_n = 1'b0;
      pd_in = 1'b0;
      mux = 1'b0;
      n_errors = 0;
      compares = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_formats();
      t_sat();
      t_latency();
      t_mux();
      t_oe();
      t_pd();
      t_regs();
      stop_test();
   end
endmodule : dual_adc_output_control_tb_top
`default_nettype wire
